// ==== common/mtm_pkg.sv ====
package mtm_pkg;
  // register offsets, consecutive
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_CLKCFG = 2'h1;
  localparam logic [1:0] ADDR_COUNT  = 2'h2;
  localparam logic [1:0] ADDR_LIMIT  = 2'h3;
  // status_control fields
  localparam int BIT_OVF   = 7;
  localparam int BIT_IRQEN = 6;
  localparam int BIT_CLEAR = 5;
  localparam int BIT_HALT  = 4;
  // clock_configuration fields
  localparam int SRC_LSB = 4;
  localparam int SRC_MSB = 5;
  localparam int DIV_LSB = 0;
  localparam int DIV_MSB = 3;
  localparam logic [3:0] DIV_MAX = 4'h8;
  // source select codes
  localparam logic [1:0] SRC_BUS  = 2'h0;
  localparam logic [1:0] SRC_FIX  = 2'h1;
  localparam logic [1:0] SRC_FALL = 2'h2;
  localparam logic [1:0] SRC_RISE = 2'h3;
  // reset values
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_LIMIT = 8'h00;
  localparam logic [1:0] RST_SRC   = 2'h0;
  localparam logic [3:0] RST_DIV   = 4'h0;
  localparam logic       RST_HALT  = 1'b1;
  localparam logic [7:0] ZERO8     = 8'h00;
  // last value before the natural wrap in free-running mode
  localparam logic [7:0] COUNT_MAX = 8'hff;
endpackage : mtm_pkg

// ==== hw/mtm_edge_sync.sv ====
`timescale 1ns/1ps
// two-flop synchroniser and edge detector for the external count pin
module mtm_edge_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // pin
  input  wire logic pin_i,
  // edges, one-cycle pulses
  output logic      rise_o,
  output logic      fall_o
);
  logic meta;
  logic sync;
  logic last;
  logic next_meta;
  logic next_sync;
  logic next_last;

  always_comb begin
    next_meta = pin_i;
    next_sync = meta;
    next_last = sync;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      last <= next_last;
    end
  end

  assign rise_o = sync & ~last;
  assign fall_o = ~sync & last;

  a_rise_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    rise_o |=> !rise_o)
    else $error("rise pulse longer than one cycle");
endmodule : mtm_edge_sync

// ==== hw/mtm_prescaler.sv ====
`timescale 1ns/1ps
// divides source ticks by 2**divide_select, at most 256, as a one-cycle enable
module mtm_prescaler #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic       src_tick_i,
  input  wire logic [3:0] divide_select_i,
  // output enable pulse
  output logic            tick_o
);
  logic [WIDTH-1:0] cnt;
  logic [WIDTH-1:0] next_cnt;
  logic [WIDTH-1:0] mask;
  logic [3:0]       sel;

  // codes above the last defined one act as the largest ratio
  always_comb begin
    sel = (divide_select_i > mtm_pkg::DIV_MAX) ? mtm_pkg::DIV_MAX
                                               : divide_select_i;
    mask = WIDTH'((9'h001 << sel) - 9'h001);
    next_cnt = cnt;
    if (src_tick_i) begin
      next_cnt = WIDTH'(cnt + 1'b1);
    end
  end

  // free-running divider: ratio change keeps the counter intact
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign tick_o = src_tick_i & ((cnt & mask) == mask);

  a_div_one: assert property (@(posedge clk_i) disable iff (rst_i)
    (divide_select_i == 4'h0) |-> (tick_o == src_tick_i))
    else $error("divide by one does not pass every tick");
endmodule : mtm_prescaler

// ==== hw/mtm_timer.sv ====
`timescale 1ns/1ps
// Behaviour
// - overflow flag sets when counter wraps to zero from the limit
// - flag clears by status read while set, then writing zero
// - counter-clear write or limit write also clears the flag
// - interrupt request equals flag and enable; reset clears enable
// - writing one to clear bit zeroes counter and flag; reads zero
// - halt bit freezes counter; resumes on clear; reset sets halt
// - unused status bits 3:0 and config bits 7:6 read zero
// - source select: bus, fixed clock, pin falling, pin rising
// - source change keeps the counter value
// - reset selects the bus clock source
// - divide select gives ratio two to the field value up to 256
// - divide codes above eight divide by 256
// - ratio change keeps the counter value
// - reset sets divide by one
// - four byte registers: status, config, counter, limit
// - count to limit then wrap; limit zero wraps at 255
// - limit write stores, zeroes counter, clears flag; reset zero
// - counter register read-only, reset to zero
// - pin synchronised before edge detection; pin at most bus/4
module mtm_timer (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // register port
  input  wire logic [1:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // count sources
  input  wire logic       fixed_freq_clock_i,
  input  wire logic       ext_count_input_i,
  // interrupt request
  output logic            irq_o
);
  logic [7:0] count;
  logic [7:0] limit;
  logic       ovf;
  logic       irq_en;
  logic       halt;
  logic [1:0] src_sel;
  logic [3:0] div_sel;
  logic       armed;
  logic [7:0] rdata;
  logic [7:0] next_count;
  logic [7:0] next_limit;
  logic       next_ovf;
  logic       next_irq_en;
  logic       next_halt;
  logic [1:0] next_src_sel;
  logic [3:0] next_div_sel;
  logic       next_armed;
  logic [7:0] next_rdata;
  logic       fix_meta;
  logic       fix_sync;
  logic       fix_last;
  logic       pin_rise;
  logic       pin_fall;
  logic       src_tick;
  logic       tick;
  logic       wrap;
  logic       wr_stat;
  logic       wr_clk;
  logic       wr_lim;
  logic       clr_cmd;

  function automatic logic hit(input logic [1:0] a, input logic [1:0] r);
    hit = (a == r);
  endfunction : hit

  mtm_edge_sync u_pin (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (ext_count_input_i),
    .rise_o (pin_rise),
    .fall_o (pin_fall)
  );

  // fixed clock also arrives from elsewhere; sampled then edge detected
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fix_meta <= 1'b0;
      fix_sync <= 1'b0;
      fix_last <= 1'b0;
    end else begin
      fix_meta <= fixed_freq_clock_i;
      fix_sync <= fix_meta;
      fix_last <= fix_sync;
    end
  end

  always_comb begin
    case (src_sel)
      mtm_pkg::SRC_BUS:  src_tick = 1'b1;
      mtm_pkg::SRC_FIX:  src_tick = fix_sync & ~fix_last;
      mtm_pkg::SRC_FALL: src_tick = pin_fall;
      mtm_pkg::SRC_RISE: src_tick = pin_rise;
      default:           src_tick = 1'b1;
    endcase
  end

  // a stopped timer feeds no ticks, so the prescaler waits too
  mtm_prescaler #(
    .WIDTH (8)
  ) u_div (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .src_tick_i      (src_tick & ~halt),
    .divide_select_i (div_sel),
    .tick_o          (tick)
  );

  always_comb begin
    wr_stat = wr_i & hit(addr_i, mtm_pkg::ADDR_STATUS);
    wr_clk  = wr_i & hit(addr_i, mtm_pkg::ADDR_CLKCFG);
    wr_lim  = wr_i & hit(addr_i, mtm_pkg::ADDR_LIMIT);
    clr_cmd = wr_stat & wdata_i[mtm_pkg::BIT_CLEAR];
    // limit zero: natural 8-bit wrap at 255
    wrap = tick & ~halt & ((limit == mtm_pkg::ZERO8) ?
           (count == mtm_pkg::COUNT_MAX) : (count == limit));

    next_limit   = limit;
    next_irq_en  = irq_en;
    next_halt    = halt;
    next_src_sel = src_sel;
    next_div_sel = div_sel;
    next_count   = count;
    next_ovf     = ovf;
    next_armed   = armed;

    if (tick && !halt) begin
      next_count = wrap ? mtm_pkg::ZERO8 : 8'(count + 8'h01);
    end
    if (wr_stat) begin
      next_irq_en = wdata_i[mtm_pkg::BIT_IRQEN];
      next_halt   = wdata_i[mtm_pkg::BIT_HALT];
      if (!wdata_i[mtm_pkg::BIT_OVF] && armed) begin
        next_ovf = 1'b0;
      end
      next_armed = 1'b0;
    end
    if (wr_clk) begin
      // source and ratio change leave the count alone
      next_src_sel = wdata_i[mtm_pkg::SRC_MSB:mtm_pkg::SRC_LSB];
      next_div_sel = wdata_i[mtm_pkg::DIV_MSB:mtm_pkg::DIV_LSB];
    end
    if (clr_cmd || wr_lim) begin
      next_count = mtm_pkg::ZERO8;
      next_ovf   = 1'b0;
      next_armed = 1'b0;
    end
    if (wr_lim) begin
      next_limit = wdata_i;
    end
    // arming needs the read to see the flag; a read with it low arms nothing
    if (rd_i && hit(addr_i, mtm_pkg::ADDR_STATUS) && ovf) begin
      next_armed = 1'b1;
    end
    // set wins over any clear in the same cycle
    if (wrap) begin
      next_ovf   = 1'b1;
      next_armed = 1'b0;
    end

    next_rdata = mtm_pkg::ZERO8;
    if (rd_i) begin
      case (addr_i)
        mtm_pkg::ADDR_STATUS: begin
          next_rdata[mtm_pkg::BIT_OVF]   = ovf;
          next_rdata[mtm_pkg::BIT_IRQEN] = irq_en;
          next_rdata[mtm_pkg::BIT_HALT]  = halt;
        end
        mtm_pkg::ADDR_CLKCFG: begin
          next_rdata[mtm_pkg::SRC_MSB:mtm_pkg::SRC_LSB] = src_sel;
          next_rdata[mtm_pkg::DIV_MSB:mtm_pkg::DIV_LSB] = div_sel;
        end
        mtm_pkg::ADDR_COUNT: next_rdata = count;
        mtm_pkg::ADDR_LIMIT: next_rdata = limit;
        default:             next_rdata = mtm_pkg::ZERO8;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count   <= mtm_pkg::RST_COUNT;
      limit   <= mtm_pkg::RST_LIMIT;
      ovf     <= 1'b0;
      irq_en  <= 1'b0;
      halt    <= mtm_pkg::RST_HALT;
      src_sel <= mtm_pkg::RST_SRC;
      div_sel <= mtm_pkg::RST_DIV;
      armed   <= 1'b0;
      rdata   <= mtm_pkg::ZERO8;
    end else begin
      count   <= next_count;
      limit   <= next_limit;
      ovf     <= next_ovf;
      irq_en  <= next_irq_en;
      halt    <= next_halt;
      src_sel <= next_src_sel;
      div_sel <= next_div_sel;
      armed   <= next_armed;
      rdata   <= next_rdata;
    end
  end

  assign rdata_o = rdata;
  assign irq_o   = ovf & irq_en;

  a_ovf_on_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
    wrap |=> (ovf && count == mtm_pkg::ZERO8))
    else $error("wrap did not set flag and zero counter");
  a_clear_unarmed: assert property (@(posedge clk_i) disable iff (rst_i)
    (ovf && !armed && wr_stat && !clr_cmd && !wr_lim) |=> ovf)
    else $error("flag cleared without arming read");
  a_clear_armed: assert property (@(posedge clk_i) disable iff (rst_i)
    (armed && wr_stat && !wdata_i[mtm_pkg::BIT_OVF] && !wrap) |=> !ovf)
    else $error("armed clear did not clear flag");
  a_limit_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_lim && !tick) |=> (count == mtm_pkg::ZERO8 && !ovf &&
                           limit == $past(wdata_i)))
    else $error("limit write effects missing");
  a_trst_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    clr_cmd |=> (count == mtm_pkg::ZERO8))
    else $error("counter clear ignored");
  a_halt_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (halt && !clr_cmd && !wr_lim) |=> $stable(count))
    else $error("counter moved while halted");
  a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o == (ovf && irq_en))
    else $error("interrupt mismatch");
  a_cfg_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_clk && !tick) |=> $stable(count))
    else $error("config write disturbed counter");
  a_unused_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(rd_i) && $past(addr_i) == mtm_pkg::ADDR_STATUS)
    |-> (rdata_o[3:0] == 4'h0 && rdata_o[mtm_pkg::BIT_CLEAR] == 1'b0))
    else $error("unused status bits not zero");
  a_count_inc: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick && !halt && !wrap && !clr_cmd && !wr_lim)
    |=> count == 8'($past(count) + 8'h01))
    else $error("counter did not increment");

  // the read port idles at zero so a late sample never sees stale data
  a_rdata_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rd_i) |-> (rdata_o == mtm_pkg::ZERO8))
    else $error("read data not zero outside read cycle");
  a_count_ro: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_i && hit(addr_i, mtm_pkg::ADDR_COUNT) && !tick)
    |=> $stable(count))
    else $error("write to counter register took effect");
  a_flag_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (ovf && !wr_stat && !wr_lim) |=> ovf)
    else $error("flag dropped without a clearing write");
  a_arm_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && hit(addr_i, mtm_pkg::ADDR_STATUS) && ovf && !wrap)
    |=> armed)
    else $error("status read with flag set did not arm");
  a_cfg_unused: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(rd_i) && $past(addr_i) == mtm_pkg::ADDR_CLKCFG)
    |-> (rdata_o[7:6] == 2'h0))
    else $error("unused config bits not zero");
  a_irqen_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_stat |=> (irq_en == $past(wdata_i[mtm_pkg::BIT_IRQEN])))
    else $error("interrupt enable write lost");
  // rearming must wait for a fresh read once a new overflow lands
  a_wrap_disarm: assert property (@(posedge clk_i) disable iff (rst_i)
    wrap |=> !armed)
    else $error("overflow left the clear armed");

  c_wrap: cover property (@(posedge clk_i) disable iff (rst_i) wrap);
  c_resume: cover property (@(posedge clk_i) disable iff (rst_i)
    $fell(halt));
  c_clear_seq: cover property (@(posedge clk_i) disable iff (rst_i)
    armed && wr_stat && !wdata_i[mtm_pkg::BIT_OVF]);
  c_pin_tick: cover property (@(posedge clk_i) disable iff (rst_i)
    tick && src_sel == mtm_pkg::SRC_RISE);
  c_irq: cover property (@(posedge clk_i) disable iff (rst_i) irq_o);
endmodule : mtm_timer

// ==== dv/mtm_timer_tb.sv ====
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      $display("Error %0t: got %h expected %h", $time, (got), (exp)); \
      fails++; \
    end \
  end

module mtm_timer_tb;
  localparam logic [1:0] A_ST = mtm_pkg::ADDR_STATUS;
  localparam logic [1:0] A_CK = mtm_pkg::ADDR_CLKCFG;
  localparam logic [1:0] A_CN = mtm_pkg::ADDR_COUNT;
  localparam logic [1:0] A_LM = mtm_pkg::ADDR_LIMIT;
  logic       clk_i;
  logic       rst_i;
  logic [1:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic [7:0] rdata_o;
  logic       fixed_freq_clock_i;
  logic       ext_count_input_i;
  logic       irq_o;
  logic [7:0] rd_val;
  logic [7:0] held;
  logic [3:0] code;
  int         fails;
  int         n_tests;
  int         ph;
  int         codes [11] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 15};

  mtm_timer dut (
    .clk_i              (clk_i),
    .rst_i              (rst_i),
    .addr_i             (addr_i),
    .wdata_i            (wdata_i),
    .wr_i               (wr_i),
    .rd_i               (rd_i),
    .rdata_o            (rdata_o),
    .fixed_freq_clock_i (fixed_freq_clock_i),
    .ext_count_input_i  (ext_count_input_i),
    .irq_o              (irq_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // slow sources: period of 8 bus cycles, inside the bus/4 limit
  always @(posedge clk_i) begin
    ph <= ph + 1;
    if (ph[1:0] == 2'h3) begin
      fixed_freq_clock_i <= ~fixed_freq_clock_i;
      ext_count_input_i  <= ~ext_count_input_i;
    end
  end

  task automatic end_of_test();
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 rd_val = rdata_o;
  endtask : rd

  task automatic chk_rd(input logic [1:0] a, input logic [7:0] e);
    rd(a);
    `CHK(rd_val, e);
  endtask : chk_rd

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle

  // count is checked in a window: the free-running prescaler may cut
  // the first period short
  task automatic cnt_near(input int e, input int tol);
    int lo;
    lo = (e > tol) ? e - tol : 0;
    rd(A_CN);
    `CHK((rd_val >= lo && rd_val <= e + tol), 1'b1);
  endtask : cnt_near

  initial begin
    rst_i = 1'b1;
    addr_i = 2'h0;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    fixed_freq_clock_i = 1'b0;
    ext_count_input_i = 1'b0;
    fails = 0;
    n_tests = 0;
    ph = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_rd(A_ST, 8'h10);
    chk_rd(A_CK, 8'h00);
    chk_rd(A_CN, 8'h00);
    chk_rd(A_LM, 8'h00);
    `CHK(irq_o, 1'b0);
    wr(A_CK, 8'hff);
    chk_rd(A_CK, 8'h3f);
    wr(A_ST, 8'hff);
    chk_rd(A_ST, 8'h50);
    wr(A_CK, 8'h00);
    wr(A_CN, 8'h55);
    chk_rd(A_CN, 8'h00);
    wr(A_LM, 8'h03);
    chk_rd(A_LM, 8'h03);
    // first overflow with the interrupt enabled
    wr(A_ST, 8'h40);
    idle(20);
    wr(A_ST, 8'h50);
    #1;
    `CHK(irq_o, 1'b1);
    rd(A_CN);
    held = rd_val;
    `CHK((rd_val <= 8'h03), 1'b1);
    idle(10);
    chk_rd(A_CN, held);
    chk_rd(A_ST, 8'hd0);
    wr(A_ST, 8'h50);
    chk_rd(A_ST, 8'h50);
    `CHK(irq_o, 1'b0);
    // clear without arming read, then overflow after the arming read
    wr(A_ST, 8'h00);
    idle(12);
    wr(A_ST, 8'h00);
    chk_rd(A_ST, 8'h80);
    idle(8);
    wr(A_ST, 8'h00);
    chk_rd(A_ST, 8'h80);
    // halt first so that no wrap lands on the clear write
    wr(A_ST, 8'h10);
    wr(A_ST, 8'h30);
    chk_rd(A_ST, 8'h10);
    chk_rd(A_CN, 8'h00);
    wr(A_ST, 8'h00);
    idle(12);
    wr(A_ST, 8'h10);
    wr(A_LM, 8'h03);
    chk_rd(A_ST, 8'h10);
    chk_rd(A_CN, 8'h00);
    // free running with limit zero, interrupt disabled
    wr(A_LM, 8'h00);
    wr(A_ST, 8'h00);
    idle(200);
    chk_rd(A_ST, 8'h00);
    idle(100);
    wr(A_ST, 8'h10);
    chk_rd(A_ST, 8'h90);
    `CHK(irq_o, 1'b0);
    // divide codes 0 to 9 and 15, wait scaled to the ratio
    for (int i = 0; i < 11; i++) begin
      code = codes[i][3:0];
      wr(A_LM, 8'h00);
      wr(A_CK, {4'h0, code});
      wr(A_ST, 8'h00);
      idle(32 << ((code > 4'h8) ? 8 : code));
      wr(A_ST, 8'h10);
      cnt_near(33, 3);
    end
    // fixed clock, then pin rising, then pin falling, without clearing
    wr(A_LM, 8'h00);
    wr(A_CK, 8'h10);
    wr(A_ST, 8'h00);
    idle(160);
    wr(A_CK, 8'h30);
    idle(160);
    wr(A_CK, 8'h20);
    idle(160);
    wr(A_ST, 8'h10);
    cnt_near(60, 4);
    // ratio change mid-run keeps the count
    wr(A_LM, 8'h00);
    wr(A_CK, 8'h00);
    wr(A_ST, 8'h00);
    idle(100);
    wr(A_CK, 8'h02);
    idle(100);
    wr(A_ST, 8'h10);
    cnt_near(128, 4);
    end_of_test();
  end

  // the tests need about 34k cycles
  initial begin
    repeat (60000) @(posedge clk_i);
    fails++;
    end_of_test();
  end
endmodule : mtm_timer_tb
